// ===== rtl/ricb_params.svh
`ifndef RICB_PARAMS_SVH
`define RICB_PARAMS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define RICB_ADDR_W          9
`define RICB_OFF_PHASE_SPAN  9'h074
`define RICB_OFF_DIFF_LO     9'h07a
`define RICB_OFF_DIFF_IN8    9'h07b
`define RICB_OFF_HALVE_LO    9'h07c

// ---------------------------------------------------------------
// reset values and fields
// ---------------------------------------------------------------
`define RICB_RST_PHASE_SPAN  8'h0a
`define RICB_RST_DIFF_LO     8'h00
`define RICB_RST_DIFF_IN8    8'h00
`define RICB_RST_HALVE_LO    8'h00
`define RICB_DIFF_IN8_BIT    0
`define RICB_NUM_DIFF        9
`define RICB_NUM_HALVE       8

`endif

// ===== rtl/ricb_pkg.sv
package ricb_pkg;
	// register access request from the serial control port decoder
	typedef struct packed {
		logic       wrEn;
		logic       rdEn;
		logic [8:0] addr;
		logic [7:0] wrData;
	} ricb_req_type;

	// configuration outputs toward the input receivers and pre-dividers
	typedef struct packed {
		logic [7:0] phaseMemorySpan;
		logic [8:0] diffSelect;
		logic [7:0] halveEnable;
	} ricb_cfg_type;
endpackage

// ===== rtl/ricb_reference_input_config_bank.sv
`timescale 1ns/10ps
`include "ricb_params.svh"
module ricb_reference_input_config_bank
(
	input  wire logic                  clk_sys,
	input  wire logic                  resetn,
	input  wire ricb_pkg::ricb_req_type regReq,
	output logic [7:0]                 rdData,
	output logic                       rdHit,
	output ricb_pkg::ricb_cfg_type      cfgOut,
	input  wire logic [8:0]            inputPositivePin,
	input  wire logic [8:0]            inputNegativePin,
	input  wire logic [7:0]            referenceInputClk,
	output logic [7:0]                 referenceToDpll,
	output logic [8:0]                 receivedInput
);
	import ricb_pkg::*;

	// ---------------------------------------------------------------
	// register storage
	// ---------------------------------------------------------------
	logic [7:0] phaseSpan_q;
	logic [7:0] diffLo_q;
	logic       diffIn8_q;
	logic [7:0] halveLo_q;
	logic [8:0] posSync1_q;
	logic [8:0] posSync2_q;
	logic [8:0] negSync1_q;
	logic [8:0] negSync2_q;
	logic [7:0] refSync1_q;
	logic [7:0] refSync2_q;
	logic [7:0] refPrev_q;
	logic [7:0] halfClk_q;
	logic [7:0] toDpll_d;
	logic [7:0] toDpll_q;
	logic [8:0] received_d;
	logic [8:0] received_q;
	logic [7:0] rdData_d;
	logic [7:0] rdData_q;
	logic       rdHit_q;

	// ---------------------------------------------------------------
	// address decode
	// ---------------------------------------------------------------
	wire selSpan  = (regReq.addr == `RICB_OFF_PHASE_SPAN);
	wire selDiffL = (regReq.addr == `RICB_OFF_DIFF_LO);
	wire selDiff8 = (regReq.addr == `RICB_OFF_DIFF_IN8);
	wire selHalve = (regReq.addr == `RICB_OFF_HALVE_LO);
	wire anySel   = selSpan | selDiffL | selDiff8 | selHalve;

	// read mux; unmapped addresses return zero
	assign rdData_d = selSpan  ? phaseSpan_q :
	                  selDiffL ? diffLo_q :
	                  selDiff8 ? {7'h00, diffIn8_q} :
	                  selHalve ? halveLo_q : 8'h00;

	// ---------------------------------------------------------------
	// write strobes
	// ---------------------------------------------------------------
	// one strobe per register keeps each write process small
	wire wrSpan  = regReq.wrEn & selSpan;
	wire wrDiffL = regReq.wrEn & selDiffL;
	wire wrDiff8 = regReq.wrEn & selDiff8;
	wire wrHalve = regReq.wrEn & selHalve;

	// reset image of the input 8 register; only its select bit is stored
	wire [7:0] rstDiffIn8 = `RICB_RST_DIFF_IN8;

	// ---------------------------------------------------------------
	// register writes
	// ---------------------------------------------------------------
	// the span code is stored raw; decoding to time is the DPLL's job
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			phaseSpan_q <= `RICB_RST_PHASE_SPAN;
		end
		else if (wrSpan)
		begin
			phaseSpan_q <= regReq.wrData;
		end
	end

	// differential selects of inputs 0 to 7
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			diffLo_q <= `RICB_RST_DIFF_LO;
		end
		else if (wrDiffL)
		begin
			diffLo_q <= regReq.wrData;
		end
	end

	// reserved bits are dropped here, so they can only read back zero
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			diffIn8_q <= rstDiffIn8[`RICB_DIFF_IN8_BIT];
		end
		else if (wrDiff8)
		begin
			diffIn8_q <= regReq.wrData[`RICB_DIFF_IN8_BIT];
		end
	end

	// halving enables of inputs 0 to 7
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			halveLo_q <= `RICB_RST_HALVE_LO;
		end
		else if (wrHalve)
		begin
			halveLo_q <= regReq.wrData;
		end
	end

	// ---------------------------------------------------------------
	// read return
	// ---------------------------------------------------------------
	// data held between reads so the host may fetch it late
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			rdData_q <= 8'h00;
		end
		else if (regReq.rdEn)
		begin
			rdData_q <= rdData_d;
		end
	end

	// hit stands one cycle; unmapped reads leave it low
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			rdHit_q <= 1'b0;
		end
		else
		begin
			rdHit_q <= regReq.rdEn & anySel;
		end
	end

	assign rdData = rdData_q;
	assign rdHit  = rdHit_q;

	// ---------------------------------------------------------------
	// configuration outputs
	// ---------------------------------------------------------------
	// straight from the registers, so they change one edge after a write
	assign cfgOut.phaseMemorySpan = phaseSpan_q;
	assign cfgOut.diffSelect      = {diffIn8_q, diffLo_q};
	assign cfgOut.halveEnable     = halveLo_q;

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	// positive pins; only the second stage reads the first
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			posSync1_q <= 9'h000;
			posSync2_q <= 9'h000;
		end
		else
		begin
			posSync1_q <= inputPositivePin;
			posSync2_q <= posSync1_q;
		end
	end

	// negative pins; asynchronous to clk_sys like the positive ones
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			negSync1_q <= 9'h000;
			negSync2_q <= 9'h000;
		end
		else
		begin
			negSync1_q <= inputNegativePin;
			negSync2_q <= negSync1_q;
		end
	end

	// reference clocks ahead of the pre-dividers
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			refSync1_q <= 8'h00;
			refSync2_q <= 8'h00;
		end
		else
		begin
			refSync1_q <= referenceInputClk;
			refSync2_q <= refSync1_q;
		end
	end

	// ---------------------------------------------------------------
	// per-input receiver (inputs 0 to 8) and pre-divider (inputs 0 to 7)
	// ---------------------------------------------------------------
	// a sampled model: only usable for references well below clk_sys/2
	genvar gi;
	generate
		for (gi = 0; gi < `RICB_NUM_DIFF; gi = gi + 1)
		begin : gRecv
			// differential compares the pair; single-ended ignores negative pin
			wire diffLevel   = posSync2_q[gi] & ~negSync2_q[gi];
			wire singleLevel = posSync2_q[gi];
			assign received_d[gi] = cfgOut.diffSelect[gi] ? diffLevel : singleLevel;
		end

		for (gi = 0; gi < `RICB_NUM_HALVE; gi = gi + 1)
		begin : gHalve
			// rising edge of the synchronised reference
			wire refRise = refSync2_q[gi] & ~refPrev_q[gi];
			// edge history; reset low like the idle pin, so no false edge
			always_ff @(posedge clk_sys)
			begin
				if (!resetn)
				begin
					refPrev_q[gi] <= 1'b0;
				end
				else
				begin
					refPrev_q[gi] <= refSync2_q[gi];
				end
			end
			// toggle on each rising edge gives the halved clock
			always_ff @(posedge clk_sys)
			begin
				if (!resetn)
				begin
					halfClk_q[gi] <= 1'b0;
				end
				else if (refRise)
				begin
					halfClk_q[gi] <= ~halfClk_q[gi];
				end
			end
			// divider keeps running while bypassed, so enabling may start mid-phase
			assign toDpll_d[gi] = halveLo_q[gi] ? halfClk_q[gi] :
				refSync2_q[gi];
		end
	endgenerate

	// ---------------------------------------------------------------
	// output flops
	// ---------------------------------------------------------------
	// clocks toward the DPLLs leave a flop, never the select mux
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			toDpll_q <= 8'h00;
		end
		else
		begin
			toDpll_q <= toDpll_d;
		end
	end

	// received levels registered like every other data output
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			received_q <= 9'h000;
		end
		else
		begin
			received_q <= received_d;
		end
	end

	assign referenceToDpll = toDpll_q;
	assign receivedInput   = received_q;
endmodule

// ===== sim/ricb_checker_assertions.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// port-level checks of the configuration bank
// ---------------------------------------------------------------
module ricb_checker
(
	input wire logic                   clk_sys,
	input wire logic                   resetn,
	input wire ricb_pkg::ricb_req_type regReq,
	input wire logic [7:0]             rdData,
	input wire logic                   rdHit,
	input wire ricb_pkg::ricb_cfg_type cfgOut,
	input wire logic [8:0]             inputPositivePin,
	input wire logic [8:0]             inputNegativePin,
	input wire logic [7:0]             referenceInputClk,
	input wire logic [7:0]             referenceToDpll,
	input wire logic [8:0]             receivedInput
);
	import ricb_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// decode mapped offsets; only a strobe makes them count
	wire logic [3:0] hit = {regReq.addr == 9'h07c, regReq.addr == 9'h07b,
		regReq.addr == 9'h07a, regReq.addr == 9'h074};
	wire logic [3:0] wrHit = hit & {4{regReq.wrEn}};
	AST_WR_SPAN: assert property (wrHit[0] |=> cfgOut.phaseMemorySpan == $past(regReq.wrData))
		else $error("span write not applied");
	AST_WR_DIFF: assert property (wrHit[1] |=> cfgOut.diffSelect[7:0] == $past(regReq.wrData))
		else $error("diff write not applied");
	AST_WR_IN8: assert property (wrHit[2] |=> cfgOut.diffSelect[8] == $past(regReq.wrData[0]))
		else $error("input 8 diff write not applied");
	AST_WR_HALVE: assert property (wrHit[3] |=> cfgOut.halveEnable == $past(regReq.wrData))
		else $error("halving write not applied");
	AST_RD_HIT: assert property (regReq.rdEn && |hit |=> rdHit)
		else $error("mapped read without hit");
	AST_RD_MISS: assert property (regReq.rdEn && !(|hit) |=> !rdHit && rdData == 8'h00)
		else $error("unmapped read answered");
	// settle window covers the two-flop pin synchroniser
	AST_RX_SINGLE: assert property ((!cfgOut.diffSelect[0] && $stable(inputPositivePin[0]))[*5]
		|-> receivedInput[0] == inputPositivePin[0]) else $error("single-ended level wrong");
	AST_RX_DIFF: assert property ((cfgOut.diffSelect[1] && $stable(inputPositivePin[1])
		&& $stable(inputNegativePin[1]))[*5] |-> receivedInput[1] ==
		(inputPositivePin[1] & ~inputNegativePin[1])) else $error("differential level wrong");
	// read returns the register value as it stood at the strobe
	AST_RD_SPAN: assert property (regReq.rdEn && hit[0] |=>
		rdData == $past(cfgOut.phaseMemorySpan)) else $error("span read value wrong");
	AST_RD_RSVD: assert property (regReq.rdEn && hit[2] |=> rdData[7:1] == 7'h00)
		else $error("reserved bits read nonzero");
	AST_HIT_PULSE: assert property (!$past(regReq.rdEn) |-> !rdHit)
		else $error("hit without a read");
	// direct path lags the pin by three edges; needs three edges out of reset
	AST_DIRECT: assert property ($past(resetn) && $past(resetn, 2) && $past(resetn, 3)
		&& !$past(cfgOut.halveEnable[1]) |-> referenceToDpll[1] ==
		$past(referenceInputClk[1], 3)) else $error("direct reference path wrong");
	cover property (rdHit);
	cover property (cfgOut.diffSelect[8]);
	cover property (cfgOut.halveEnable[0] && $rose(referenceToDpll[0]));
endmodule

bind ricb_reference_input_config_bank ricb_checker u_chk (.clk_sys(clk_sys), .resetn(resetn),
	.regReq(regReq), .rdData(rdData), .rdHit(rdHit), .cfgOut(cfgOut),
	.inputPositivePin(inputPositivePin), .inputNegativePin(inputNegativePin),
	.referenceInputClk(referenceInputClk), .referenceToDpll(referenceToDpll),
	.receivedInput(receivedInput));

// ===== sim/tb_top.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// bench for the configuration bank
// ---------------------------------------------------------------
module tb_top;
	import ricb_pkg::*;
	logic         clk_sys = 1'b0;
	logic         resetn = 1'b0;
	ricb_req_type regReq = '0;
	ricb_cfg_type cfgOut;
	logic [7:0]   rdData, refOut;
	logic [7:0]   refClk = 8'h00;
	logic [8:0]   posPin = 9'h000;
	logic [8:0]   negPin = 9'h000;
	logic [8:0]   rxIn;
	logic         rdHit;
	int           bad_count = 0;
	int           total_checks = 0;
	int           cycles = 0;
	// 100 ns clock; hang guard well above the ~93 cycles needed
	always #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
		if (++cycles > 3000)
		begin
			bad_count++;
			wrap_up();
		end
	ricb_reference_input_config_bank dut_u (.clk_sys(clk_sys), .resetn(resetn),
		.regReq(regReq), .rdData(rdData), .rdHit(rdHit), .cfgOut(cfgOut),
		.inputPositivePin(posPin), .inputNegativePin(negPin), .referenceInputClk(refClk),
		.referenceToDpll(refOut), .receivedInput(rxIn));
	// compare and count
	task automatic check(string what, logic [24:0] seen, logic [24:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
			bad_count++;
		end
	endtask
	// strobes last one cycle, driven on the falling edge
	task automatic wr(logic [8:0] a, logic [7:0] d);
		@(negedge clk_sys) regReq = '{1'b1, 1'b0, a, d};
		@(negedge clk_sys) regReq.wrEn = 1'b0;
	endtask
	task automatic rdc(string what, logic [8:0] a, logic [7:0] d, logic h);
		@(negedge clk_sys) regReq = '{1'b0, 1'b1, a, 8'h00};
		@(negedge clk_sys) regReq.rdEn = 1'b0;
		check(what, rdData, d);
		check("hit", rdHit, h);
	endtask
	task automatic testReset();
		rdc("span", 9'h074, 8'h0a, 1'b1);
		rdc("diff", 9'h07a, 8'h00, 1'b1);
		rdc("in8", 9'h07b, 8'h00, 1'b1);
		rdc("halve", 9'h07c, 8'h00, 1'b1);
		$display("reset values done");
	endtask
	// reserved bits and an unmapped hole must not stick
	task automatic testRegs();
		wr(9'h074, 8'h5a);
		wr(9'h07a, 8'ha5);
		wr(9'h07b, 8'hff);
		wr(9'h07c, 8'h3c);
		wr(9'h075, 8'hff);
		check("cfg", cfgOut, {8'h5a, 9'h1a5, 8'h3c});
		rdc("span", 9'h074, 8'h5a, 1'b1);
		rdc("in8", 9'h07b, 8'h01, 1'b1);
		rdc("halve", 9'h07c, 8'h3c, 1'b1);
		rdc("hole", 9'h075, 8'h00, 1'b0);
		rdc("diff", 9'h07a, 8'ha5, 1'b1);
		wr(9'h074, 8'h40);
		check("span 1 ms", cfgOut.phaseMemorySpan, 8'h40);
		rdc("span 1 ms", 9'h074, 8'h40, 1'b1);
		$display("register access done");
	endtask
	task automatic testRx();
		wr(9'h07a, 8'h02);
		posPin = 9'h103;
		negPin = 9'h003;
		repeat (6) @(negedge clk_sys);
		check("rx", rxIn, 9'h101);
		$display("reception done");
	endtask
	// 8 reference periods: direct path rises 8 times, halved 4
	task automatic testHalve();
		logic [24:0] r0 = '0;
		logic [24:0] r1 = '0;
		logic [7:0]  prev;
		wr(9'h07c, 8'h01);
		prev = refOut;
		for (int i = 0; i < 40; i++)
		begin
			@(negedge clk_sys);
			if (i < 32 && i % 2 == 0)
				refClk = ~refClk;
			r0 += 25'(refOut[0] & ~prev[0]);
			r1 += 25'(refOut[1] & ~prev[1]);
			prev = refOut;
		end
		check("halved", r0, 25'd4);
		check("direct", r1, 25'd8);
		$display("pre-divider done");
	endtask
	// reset mid-run: registers and pipes return to their reset state
	task automatic testMidReset();
		@(negedge clk_sys) resetn = 1'b0;
		repeat (2) @(negedge clk_sys);
		check("rst cfg", cfgOut, {8'h0a, 9'h000, 8'h00});
		check("rst rd", {rdHit, rdData}, 9'h000);
		check("rst pins", {refOut, rxIn}, 17'h00000);
		resetn = 1'b1;
		repeat (4) @(negedge clk_sys);
		check("rx single", rxIn, 9'h103);
		rdc("span", 9'h074, 8'h0a, 1'b1);
		$display("mid-run reset done");
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(negedge clk_sys);
		resetn = 1'b1;
		testReset();
		testRegs();
		testRx();
		testHalve();
		testMidReset();
		wrap_up();
	end
endmodule
